// ---- alarm_pin_and_reset_control.sv ----
// Alarm and interrupt pin control with external reset and self-calibration sequencing
//
// Notes on behaviour
// - External reset pin is active low; low means full hardware reset.
// - During external reset all registers except the synchronisers, alarm filter and bus state go to defaults.
// - Both clock outputs are tristated while external reset is asserted.
// - Rising external reset starts self-calibration before normal operation.
// - Function select one makes the shared pin the interrupt output.
// - Interrupt on shared pin is maskable, level set by interrupt polarity.
// - Input-1 enable with function select zero reports input-one alarms there.
// - Alarm mode shows zero for input present, one for alarm, pre-inversion.
// - Alarm polarity bit sets asserted level of input-one alarm indication.
// - Neither function selected leaves the shared pin tristated.
// - Input-2 enable drives second pin as input-two alarm indicator.
// - Second pin shows zero for present, one for alarm, pre-inversion.
// - Alarm polarity bit inverts asserted level of the second pin.
// - Input-2 enable zero leaves the second pin tristated.
// - With input clocks alarmed the frequency word holds its last value.
`timescale 1ns/10ps
module alarm_pin_and_reset_control (
  input wire logic clk_in, // 100 MHz system clock
  input wire logic rst_in, // Chip reset, async, active high
  input wire logic ext_reset_n_in, // External reset pin, active low
  input wire alarm_ctl_pkg::alarm_t clock_alarms_in, // Raw input clock monitor alarms
  input wire logic [15:0] dco_word_in, // Frequency word from loop
  input wire logic hsel_in, // AHB slave select
  input wire logic [31:0] haddr_in, // AHB address
  input wire logic [1:0] htrans_in, // AHB transfer type
  input wire logic hwrite_in, // AHB write flag
  input wire logic [2:0] hsize_in, // AHB size, word only
  input wire logic [31:0] hwdata_in, // AHB write data
  input wire logic hready_in, // AHB bus ready
  output logic [31:0] hrdata_out, // AHB read data
  output logic hreadyout_out, // AHB slave ready
  output logic hresp_out, // AHB response
  output logic irq_or_input1_alarm_out, // Shared pin level
  output logic irq_or_input1_alarm_oe_out, // Shared pin drive enable
  output logic input2_alarm_out, // Second alarm pin level
  output logic input2_alarm_oe_out, // Second alarm pin drive enable
  output logic irq_out, // Level interrupt, active high
  output logic [1:0] clk_out_enable_out, // Clock output drive enables
  output logic cal_busy_out, // Self-calibration running
  output logic holdover_out, // Frequency word frozen
  output logic [15:0] dco_word_out // Frequency word to synthesiser
);

  alarm_ctl_pkg::state_t st;
  alarm_ctl_pkg::state_t st_nxt;

  // Read mux of the register file; unmapped words read as zero
  function automatic logic [31:0] read_mux(input alarm_ctl_pkg::state_t s,
                                           input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      alarm_ctl_pkg::CTRL_OFFSET: v[alarm_ctl_pkg::CTRL_W-1:0] = s.ctrl;
      alarm_ctl_pkg::STATUS_OFFSET: v[alarm_ctl_pkg::EVENT_W-1:0] = s.stat;
      alarm_ctl_pkg::MASK_OFFSET: v[alarm_ctl_pkg::EVENT_W-1:0] = s.mask;
      alarm_ctl_pkg::LIVE_OFFSET: v[alarm_ctl_pkg::ALARM_W+2:0] =
        {s.phase == alarm_ctl_pkg::PH_CAL, s.ext_n, s.hold, s.alm_f};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : read_mux

  // Combinational next state
  always_comb begin
    logic [3:0] diff;
    logic [3:0] alm_new;
    logic alarm1;
    logic alarm2;
    logic irq_lvl;
    logic accept;
    logic [4:0] w1c;
    logic [4:0] set;
    logic cal_end;
    diff = 4'h0;
    alm_new = 4'h0;
    alarm1 = 1'b0;
    alarm2 = 1'b0;
    irq_lvl = 1'b0;
    accept = 1'b0;
    w1c = 5'h00;
    set = 5'h00;
    cal_end = 1'b0;
    st_nxt = st;

    // Three-stage synchronisers; the first stage feeds only the second
    st_nxt.ext_s1 = ext_reset_n_in;
    st_nxt.ext_s2 = st.ext_s1;
    st_nxt.ext_s3 = st.ext_s2;
    st_nxt.alm_s1 = clock_alarms_in;
    st_nxt.alm_s2 = st.alm_s1;
    st_nxt.alm_s3 = st.alm_s2;

    // A change counts once stages two and three agree
    if (st.ext_s2 == st.ext_s3) begin
      st_nxt.ext_n = st.ext_s3;
    end
    diff = st.alm_s2 ^ st.alm_s3;
    alm_new = (st.alm_s3 & ~diff) | (st.alm_f & diff);
    st_nxt.alm_f = alm_new;

    // Pin alarm terms, offset alarm only when enabled
    alarm1 = st.alm_f.loss_of_signal_alarm_one |
             (st.ctrl.fos1_enable & st.alm_f.frequency_offset_alarm_one);
    alarm2 = st.alm_f.loss_of_signal_alarm_two |
             (st.ctrl.fos2_enable & st.alm_f.frequency_offset_alarm_two);
    irq_lvl = |(st.stat & st.mask);

    // Reset, calibration and run sequence
    unique case (st.phase)
      alarm_ctl_pkg::PH_RESET: begin
        if (st.ext_n) begin
          st_nxt.phase = alarm_ctl_pkg::PH_CAL;
          st_nxt.cal_cnt = alarm_ctl_pkg::CAL_CNT_RESET;
        end
      end
      alarm_ctl_pkg::PH_CAL: begin
        st_nxt.cal_cnt = st.cal_cnt + 8'h01;
        if (st.cal_cnt == alarm_ctl_pkg::CAL_LAST) begin
          st_nxt.phase = alarm_ctl_pkg::PH_RUN;
          cal_end = 1'b1;
        end
      end
      alarm_ctl_pkg::PH_RUN: begin
        st_nxt.cal_cnt = st.cal_cnt;
      end
    endcase

    // Clock outputs driven only in normal operation
    st_nxt.clk_oe = (st.phase == alarm_ctl_pkg::PH_RUN) ? 2'b11 : 2'b00;

    // AHB address phase; read data is captured here into a flop
    accept = hsel_in & hready_in & htrans_in[alarm_ctl_pkg::HTRANS_ACTIVE_POS];
    st_nxt.dph.valid = accept;
    st_nxt.dph.write = hwrite_in;
    st_nxt.dph.addr = {haddr_in[alarm_ctl_pkg::ADDR_W-1:2], 2'b00};
    if (accept && !hwrite_in) begin
      st_nxt.rdata = read_mux(st, {haddr_in[alarm_ctl_pkg::ADDR_W-1:2], 2'b00});
    end

    // AHB data phase writes
    if (st.dph.valid && st.dph.write) begin
      unique case (st.dph.addr)
        alarm_ctl_pkg::CTRL_OFFSET: st_nxt.ctrl = hwdata_in[alarm_ctl_pkg::CTRL_W-1:0];
        alarm_ctl_pkg::STATUS_OFFSET: w1c = hwdata_in[alarm_ctl_pkg::EVENT_W-1:0];
        alarm_ctl_pkg::MASK_OFFSET: st_nxt.mask = hwdata_in[alarm_ctl_pkg::EVENT_W-1:0];
        default: w1c = 5'h00;
      endcase
    end

    // Sticky events: a new event beats a same-cycle clear
    set = {cal_end, alm_new & ~st.alm_f};
    st_nxt.stat = (st.stat & ~w1c) | set;

    // Freeze frequency word while both inputs are in alarm
    st_nxt.hold = alarm1 & alarm2;
    if (!st.hold) begin
      st_nxt.dco = dco_word_in;
    end

    // Shared pin: interrupt, input-one alarm, or tristate
    if (st.ctrl.int_function_select) begin
      st_nxt.pin1_oe = 1'b1;
      st_nxt.pin1 = ~(irq_lvl ^ st.ctrl.irq_polarity);
    end else if (st.ctrl.input1_alarm_out_enable) begin
      st_nxt.pin1_oe = 1'b1;
      st_nxt.pin1 = ~(alarm1 ^ st.ctrl.alarm_polarity);
    end else begin
      st_nxt.pin1_oe = 1'b0;
      st_nxt.pin1 = 1'b0;
    end

    // Second pin: input-two alarm or tristate
    if (st.ctrl.input2_alarm_out_enable) begin
      st_nxt.pin2_oe = 1'b1;
      st_nxt.pin2 = ~(alarm2 ^ st.ctrl.alarm_polarity);
    end else begin
      st_nxt.pin2_oe = 1'b0;
      st_nxt.pin2 = 1'b0;
    end
    st_nxt.irq = irq_lvl;

    // External reset low overrides all but the synchronisers, alarm filter and bus state
    if (!st.ext_n) begin
      st_nxt.phase = alarm_ctl_pkg::PH_RESET;
      st_nxt.cal_cnt = alarm_ctl_pkg::CAL_CNT_RESET;
      st_nxt.ctrl = alarm_ctl_pkg::CTRL_RESET;
      st_nxt.stat = alarm_ctl_pkg::EVENT_RESET;
      st_nxt.mask = alarm_ctl_pkg::MASK_RESET;
      st_nxt.hold = 1'b0;
      st_nxt.dco = alarm_ctl_pkg::DCO_RESET;
      st_nxt.pin1 = 1'b0;
      st_nxt.pin1_oe = 1'b0;
      st_nxt.pin2 = 1'b0;
      st_nxt.pin2_oe = 1'b0;
      st_nxt.irq = 1'b0;
      st_nxt.clk_oe = 2'b00;
    end
  end

  // State register; external reset starts asserted until synchronised high
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= st_nxt;
    end
  end

  // Outputs; zero wait states so the bus never stalls
  assign hreadyout_out = 1'b1;
  assign hresp_out = alarm_ctl_pkg::HRESP_OKAY;
  assign hrdata_out = st.rdata;
  assign irq_or_input1_alarm_out = st.pin1;
  assign irq_or_input1_alarm_oe_out = st.pin1_oe;
  assign input2_alarm_out = st.pin2;
  assign input2_alarm_oe_out = st.pin2_oe;
  assign irq_out = st.irq;
  assign clk_out_enable_out = st.clk_oe;
  assign cal_busy_out = (st.phase == alarm_ctl_pkg::PH_CAL);
  assign holdover_out = st.hold;
  assign dco_word_out = st.dco;

  // Checks on reset sequencing
  a_ext_reset_low: assert property (@(posedge clk_in) disable iff (rst_in)
    !st.ext_n |=> st.phase == alarm_ctl_pkg::PH_RESET)
    else $error("external reset low did not hold reset phase");
  a_reset_defaults: assert property (@(posedge clk_in) disable iff (rst_in)
    !st.ext_n |=> (st.ctrl == alarm_ctl_pkg::CTRL_RESET && st.stat == 5'h00
                   && st.mask == 5'h00 && !irq_out))
    else $error("registers not at default during external reset");
  a_clk_tristate: assert property (@(posedge clk_in) disable iff (rst_in)
    (!st.ext_n || st.phase == alarm_ctl_pkg::PH_RESET) |=> clk_out_enable_out == 2'b00)
    else $error("clock outputs driven during reset");
  a_cal_start: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.phase == alarm_ctl_pkg::PH_RESET && st.ext_n) |=> ##[0:2] cal_busy_out)
    else $error("calibration did not start after reset release");

  // Checks on the shared pin
  a_irq_pin_level: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_n && st.ctrl.int_function_select) |=>
      (irq_or_input1_alarm_oe_out &&
       irq_or_input1_alarm_out == ~(irq_out ^ $past(st.ctrl.irq_polarity))))
    else $error("interrupt pin level or enable wrong");
  a_alarm1_pin: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_n && !st.ctrl.int_function_select && st.ctrl.input1_alarm_out_enable) |=>
      (irq_or_input1_alarm_oe_out && irq_or_input1_alarm_out ==
       ~(($past(st.alm_f.loss_of_signal_alarm_one) |
          ($past(st.ctrl.fos1_enable) & $past(st.alm_f.frequency_offset_alarm_one)))
         ^ $past(st.ctrl.alarm_polarity))))
    else $error("input one alarm pin wrong");
  a_pin1_tristate: assert property (@(posedge clk_in) disable iff (rst_in)
    (!st.ctrl.int_function_select && !st.ctrl.input1_alarm_out_enable) |=>
      !irq_or_input1_alarm_oe_out)
    else $error("shared pin driven with no function");

  // Checks on the second pin
  a_alarm2_pin: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_n && st.ctrl.input2_alarm_out_enable) |=>
      (input2_alarm_oe_out && input2_alarm_out ==
       ~(($past(st.alm_f.loss_of_signal_alarm_two) |
          ($past(st.ctrl.fos2_enable) & $past(st.alm_f.frequency_offset_alarm_two)))
         ^ $past(st.ctrl.alarm_polarity))))
    else $error("input two alarm pin wrong");
  a_pin2_tristate: assert property (@(posedge clk_in) disable iff (rst_in)
    !st.ctrl.input2_alarm_out_enable |=> !input2_alarm_oe_out)
    else $error("second pin driven while disabled");

  // Checks on holdover and interrupt level
  a_freq_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_n && holdover_out) |=> $stable(dco_word_out))
    else $error("frequency word moved during holdover");
  a_irq_follows: assert property (@(posedge clk_in) disable iff (rst_in)
    st.ext_n |=> irq_out == |($past(st.stat) & $past(st.mask)))
    else $error("interrupt level does not follow unmasked events");

  // Holdover and frequency word; a single alarmed input must not freeze the loop
  a_dco_track: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_n && !holdover_out) |=> dco_word_out == $past(dco_word_in))
    else $error("frequency word did not track its input");
  a_hold_one_ok: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_n && !st.alm_f.loss_of_signal_alarm_one && !st.alm_f.frequency_offset_alarm_one)
      |=> !holdover_out)
    else $error("holdover while input one is healthy");
  a_hold_two_ok: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_n && !st.alm_f.loss_of_signal_alarm_two && !st.alm_f.frequency_offset_alarm_two)
      |=> !holdover_out)
    else $error("holdover while input two is healthy");

  // Calibration sequencing; the counter end point decides the calibration length
  a_cal_running: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_n && cal_busy_out && st.cal_cnt != alarm_ctl_pkg::CAL_LAST) |=> cal_busy_out)
    else $error("calibration ended early");
  a_cal_finish: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_n && cal_busy_out && st.cal_cnt == alarm_ctl_pkg::CAL_LAST) |=>
      (st.phase == alarm_ctl_pkg::PH_RUN && st.stat.cal_done))
    else $error("calibration did not finish into run");
  a_cal_count_range: assert property (@(posedge clk_in) disable iff (rst_in)
    cal_busy_out |-> st.cal_cnt <= alarm_ctl_pkg::CAL_LAST)
    else $error("calibration counter past its end");
  a_run_stays: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_n && st.phase == alarm_ctl_pkg::PH_RUN) |=> st.phase == alarm_ctl_pkg::PH_RUN)
    else $error("run phase left without reset");
  a_clk_run: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_n && st.phase == alarm_ctl_pkg::PH_RUN) |=> clk_out_enable_out == 2'b11)
    else $error("clock outputs off in run phase");
  a_clk_cal_off: assert property (@(posedge clk_in) disable iff (rst_in)
    cal_busy_out |=> clk_out_enable_out == 2'b00)
    else $error("clock outputs driven during calibration");

  // Synchroniser filter: one disagreeing sample must not move the reset level
  a_sync_filter: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_s2 != st.ext_s3) |=> $stable(st.ext_n))
    else $error("filtered reset moved on a disagreeing sample");

  // Sticky status and interrupt masking
  a_event_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_n && !(st.dph.valid && st.dph.write &&
                   st.dph.addr == alarm_ctl_pkg::STATUS_OFFSET)) |=>
      (st.stat & $past(st.stat)) == $past(st.stat))
    else $error("status bit cleared without a write");
  a_rise_sets: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_n && !st.alm_f.loss_of_signal_alarm_one) ##1 st.alm_f.loss_of_signal_alarm_one
      |-> st.stat.rise.loss_of_signal_alarm_one)
    else $error("alarm rise did not set its status bit");
  a_irq_masked: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_n && st.mask == 5'h00) |=> !irq_out)
    else $error("interrupt raised with every event masked");
  a_irq_pin_off: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_n && st.ctrl.int_function_select && st.mask == 5'h00) |=>
      irq_or_input1_alarm_out == !$past(st.ctrl.irq_polarity))
    else $error("interrupt pin not at its inactive level");

  // Offset alarm ignored when its enable is clear
  a_fos1_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_n && !st.ctrl.int_function_select && st.ctrl.input1_alarm_out_enable &&
     !st.ctrl.fos1_enable && !st.alm_f.loss_of_signal_alarm_one) |=>
      irq_or_input1_alarm_out == !$past(st.ctrl.alarm_polarity))
    else $error("disabled offset alarm reached the shared pin");
  a_fos2_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.ext_n && st.ctrl.input2_alarm_out_enable && !st.ctrl.fos2_enable &&
     !st.alm_f.loss_of_signal_alarm_two) |=>
      input2_alarm_out == !$past(st.ctrl.alarm_polarity))
    else $error("disabled offset alarm reached the second pin");

  // Undriven pins are parked low so a stale level never leaks out
  a_pin1_idle_low: assert property (@(posedge clk_in) disable iff (rst_in)
    !irq_or_input1_alarm_oe_out |-> !irq_or_input1_alarm_out)
    else $error("shared pin level not parked while undriven");
  a_pin2_idle_low: assert property (@(posedge clk_in) disable iff (rst_in)
    !input2_alarm_oe_out |-> !input2_alarm_out)
    else $error("second pin level not parked while undriven");

endmodule : alarm_pin_and_reset_control

// ---- alarm_ctl_pkg.sv ----
// Package with register map, field layouts, timing and state types of the alarm pin control
package alarm_ctl_pkg;

  // Register byte offsets, one aligned word each
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] MASK_OFFSET = 8'h08;
  localparam logic [7:0] LIVE_OFFSET = 8'h0c;

  // AHB-Lite encodings
  localparam int HTRANS_ACTIVE_POS = 1;
  localparam logic HRESP_OKAY = 1'b0;

  // Control register layout, top bit first, bit 0 last
  typedef struct packed {
    logic fos2_enable;
    logic fos1_enable;
    logic alarm_polarity;
    logic input2_alarm_out_enable;
    logic input1_alarm_out_enable;
    logic irq_polarity;
    logic int_function_select;
  } ctrl_t;
  localparam int CTRL_W = 7;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // Monitor alarms of both clock inputs
  typedef struct packed {
    logic frequency_offset_alarm_two;
    logic loss_of_signal_alarm_two;
    logic frequency_offset_alarm_one;
    logic loss_of_signal_alarm_one;
  } alarm_t;
  localparam int ALARM_W = 4;
  localparam logic [3:0] ALARM_RESET = 4'h0;

  // Sticky event layout, shared by status and mask
  typedef struct packed {
    logic cal_done;
    alarm_t rise;
  } event_t;
  localparam int EVENT_W = 5;
  localparam logic [4:0] EVENT_RESET = 5'h00;
  localparam logic [4:0] MASK_RESET = 5'h00;

  // Self-calibration time after external reset release
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAL_TIME_NS = 1000;
  localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_CNT_W = 8;
  localparam logic [7:0] CAL_LAST = 8'(CAL_CYCLES - 1);
  localparam logic [7:0] CAL_CNT_RESET = 8'h00;

  // Frequency word width and reset value
  localparam int DCO_W = 16;
  localparam logic [15:0] DCO_RESET = 16'h0000;

  typedef enum logic [1:0] {PH_RESET, PH_CAL, PH_RUN} phase_t;

  // Pending AHB data phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } dphase_t;

  // Whole state of the block
  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic ext_n;
    alarm_t alm_s1;
    alarm_t alm_s2;
    alarm_t alm_s3;
    alarm_t alm_f;
    phase_t phase;
    logic [7:0] cal_cnt;
    ctrl_t ctrl;
    event_t stat;
    event_t mask;
    dphase_t dph;
    logic [31:0] rdata;
    logic hold;
    logic [15:0] dco;
    logic pin1;
    logic pin1_oe;
    logic pin2;
    logic pin2_oe;
    logic irq;
    logic [1:0] clk_oe;
  } state_t;

endpackage : alarm_ctl_pkg

// ---- alarm_host_model.sv ----
// Host side model: drives the external reset pin and views the two alarm pins
`timescale 1ns/10ps
module alarm_host_model (
  input wire logic clk_in, // System clock
  input wire logic reset_req_in, // Bench asks for external reset
  input wire logic pin1_in, // Shared pin level
  input wire logic pin1_oe_in, // Shared pin drive enable
  input wire logic pin2_in, // Second pin level
  input wire logic pin2_oe_in, // Second pin drive enable
  output logic ext_reset_n_out, // External reset, active low
  output logic pin1_seen_out, // Level seen on shared pin
  output logic pin2_seen_out // Level seen on second pin
);
  logic last1_r = 1'b0;
  logic last2_r = 1'b0;
  logic rst_pin_r = 1'b1;
  // Reset line moves only just after an edge, like a real host
  always @(posedge clk_in) begin
    rst_pin_r <= ~reset_req_in;
    if (pin1_oe_in) last1_r <= pin1_in;
    if (pin2_oe_in) last2_r <= pin2_in;
  end
  // Floating pin shows inverse of last level, so a stale copy never passes
  assign pin1_seen_out = pin1_oe_in ? pin1_in : ~last1_r;
  assign pin2_seen_out = pin2_oe_in ? pin2_in : ~last2_r;
  assign ext_reset_n_out = rst_pin_r;
endmodule : alarm_host_model

// ---- alarm_pin_and_reset_control_test.sv ----
// Self-checking bench for the alarm pin and reset control block
`timescale 1ns/10ps
module alarm_pin_and_reset_control_test;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic reset_req = 1'b0;
  alarm_ctl_pkg::alarm_t alarms = 4'h0;
  logic [15:0] dco_in = 16'h0000;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic [1:0] clk_oe;
  logic [15:0] dco_out;
  logic [15:0] held;
  logic [15:0] dco_prev = 16'h0000;
  logic [6:0] ctl;
  logic hready, hresp, pin1, oe1, pin2, oe2, irq, busy, hold, ext_n, seen1, seen2, a1, a2;
  logic rd_dp = 1'b0;
  logic [31:0] exp_q[$];
  int failures = 0;
  int cmp_count = 0;
  int seed = 13;

  // Free running clock
  initial begin
    forever #5 clk_in = ~clk_in;
  end

  // Frequency word keeps moving so a freeze is visible
  always @(posedge clk_in) begin
    dco_in <= 16'($random(seed));
    dco_prev <= dco_in;
  end

  alarm_pin_and_reset_control u_alarm_pin_and_reset_control (
    .clk_in(clk_in), .rst_in(rst_in), .ext_reset_n_in(ext_n), .clock_alarms_in(alarms),
    .dco_word_in(dco_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .irq_or_input1_alarm_out(pin1), .irq_or_input1_alarm_oe_out(oe1),
    .input2_alarm_out(pin2), .input2_alarm_oe_out(oe2), .irq_out(irq),
    .clk_out_enable_out(clk_oe), .cal_busy_out(busy), .holdover_out(hold),
    .dco_word_out(dco_out));

  alarm_host_model u_alarm_host_model (
    .clk_in(clk_in), .reset_req_in(reset_req), .pin1_in(pin1), .pin1_oe_in(oe1),
    .pin2_in(pin2), .pin2_oe_in(oe2), .ext_reset_n_out(ext_n),
    .pin1_seen_out(seen1), .pin2_seen_out(seen2));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc

  // One single word transfer; hold each phase until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do begin
      @(posedge clk_in);
    end while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= ~wr;
    do begin
      @(posedge clk_in);
    end while (hready !== 1'b1);
    rd_dp <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, a, 32'h00000000);
  endtask : rd

  // Read data compared against the oldest note at the end of the data phase
  always @(posedge clk_in) begin
    if (rd_dp === 1'b1 && hready === 1'b1) begin
      check(hrdata, exp_q.pop_front());
      check(hresp, 1'b0);
    end
  end

  task automatic pins(input logic e1, input logic v1, input logic e2, input logic v2);
    check(oe1, e1);
    if (e1) check(seen1, v1);
    check(oe2, e2);
    if (e2) check(seen2, v2);
  endtask : pins

  // Calibration must run with clock outputs off, then enable them
  task automatic wait_cal;
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 40) begin cyc(1); n++; end
    check(busy, 1'b1);
    check(clk_oe, 2'h0);
    n = 0;
    while (busy !== 1'b0 && n < 200) begin cyc(1); n++; end
    check(busy, 1'b0);
    cyc(2);
    check(clk_oe, 2'h3);
  endtask : wait_cal

  // Main sequence
  initial begin
    cyc(5);
    rst_in <= 1'b0;
    wait_cal();
    rd(8'h04, 32'h10);
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h0c, 32'h20);
    pins(0, 0, 0, 0);
    // Random pin setups in alarm mode against random alarm inputs
    for (int i = 0; i < 16; i++) begin
      ctl = 7'($random(seed)) & 7'h7c;
      alarms <= 4'($random(seed));
      bus(1'b1, 8'h00, {25'h0, ctl});
      cyc(8);
      a1 = alarms[0] | (alarms[1] & ctl[5]);
      a2 = alarms[2] | (alarms[3] & ctl[6]);
      pins(ctl[2], ~(a1 ^ ctl[4]), ctl[3], ~(a2 ^ ctl[4]));
      check(hold, a1 & a2);
      held = dco_out;
      cyc(3);
      if (a1 & a2) check(dco_out, held);
      else check(dco_out, dco_prev);
    end
    // Interrupt mode with both polarities
    for (int p = 0; p < 2; p++) begin
      alarms <= 4'h0;
      bus(1'b1, 8'h08, 32'h0);
      cyc(8);
      bus(1'b1, 8'h04, 32'h1f);
      bus(1'b1, 8'h00, {30'h0, p[0], 1'b1});
      alarms <= 4'h1;
      cyc(8);
      check(irq, 1'b0);
      pins(1, ~p[0], 0, 0);
      rd(8'h04, 32'h01);
      bus(1'b1, 8'h08, 32'h01);
      cyc(3);
      check(irq, 1'b1);
      pins(1, p[0], 0, 0);
      alarms <= 4'h0;
      cyc(8);
      check(irq, 1'b1);
      bus(1'b1, 8'h04, 32'h01);
      cyc(3);
      check(irq, 1'b0);
      pins(1, ~p[0], 0, 0);
    end
    // External reset in mid-run
    bus(1'b1, 8'h00, 32'h0c);
    cyc(4);
    pins(1, 1, 1, 1);
    reset_req <= 1'b1;
    cyc(8);
    check(clk_oe, 2'h0);
    pins(0, 0, 0, 0);
    bus(1'b1, 8'h00, 32'h0c);
    reset_req <= 1'b0;
    wait_cal();
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    cyc(2);
    give_verdict();
  end

  // Hang guard
  initial begin
    #100000;
    failures++;
    give_verdict();
  end
endmodule : alarm_pin_and_reset_control_test
